// file: fbp_pkg.sv
package fbp_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned US_HZ = 1_000_000;
  localparam logic [7:0] USEC_RST = 8'(CLK_HZ / US_HZ);
  localparam int unsigned COMMIT_TIME_US = 20;
  localparam int unsigned BLOCK_SHIFT = 11;

  // protection codes, 2'h3 is not a legal setting
  typedef enum logic [1:0] {
    prot_unrestricted = 2'h0,
    prot_no_write = 2'h1,
    prot_fetch_only = 2'h2
  } fbp_prot_t;
  localparam logic [1:0] PROT_NONE = 2'h3;

  // access kinds seen at the flash port
  typedef enum logic [1:0] {
    acc_data_read = 2'h0,
    acc_fetch = 2'h1,
    acc_erase = 2'h2,
    acc_program = 2'h3
  } fbp_acc_t;

  // commit sequencer states
  typedef enum logic [2:0] {
    cst_idle = 3'h1,
    cst_prog = 3'h2,
    cst_done = 3'h4
  } fbp_cst_t;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PROT_ADDR = 8'h04;
  localparam logic [7:0] OFS_PROT_VAL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_USEC = 8'h10;
  localparam logic [7:0] OFS_USER0 = 8'h14;
  localparam logic [7:0] OFS_USER1 = 8'h18;
  localparam logic [7:0] OFS_INT_STAT = 8'h1C;
  localparam logic [7:0] OFS_INT_MASK = 8'h20;

  // field positions
  localparam int unsigned CTRL_COMMIT_PROT = 0;
  localparam int unsigned CTRL_COMMIT_USER = 1;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_DONE = 1;
  localparam int unsigned ST_ERR = 2;
  localparam int unsigned ST_SET_FAIL = 3;
  localparam int unsigned ST_KIND = 4;
  localparam int unsigned INT_ACCESS = 0;
  localparam int unsigned INT_PROG = 1;
  localparam int unsigned INT_COMMIT = 2;
  localparam int unsigned INT_W = 3;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [INT_W-1:0] RST_INT = 3'h0;

endpackage

// file: fbp_commit_if.sv
// commit request and microsecond timing between register core and sequencer
interface fbp_commit_if;
  logic start;
  logic kind;
  logic [7:0] clocks_per_microsecond;
  logic busy;
  logic done;
  logic err;
  logic usec_tick;

  modport ctl (output start, output kind, output clocks_per_microsecond,
               input busy, input done, input err, input usec_tick);
  modport seq (input start, input kind, input clocks_per_microsecond,
               output busy, output done, output err, output usec_tick);
endinterface

// file: fbp_commit_seq.sv
module fbp_commit_seq
  import fbp_pkg::*;
#(
  parameter int unsigned COMMIT_US = COMMIT_TIME_US
) (
  input wire logic pclk,
  input wire logic presetn,
  fbp_commit_if.seq cif,
  input wire logic nv_error,
  output logic nv_wr_en,
  output logic nv_wr_kind
);
  fbp_cst_t state_ff;
  logic [7:0] div_ff;
  logic [15:0] us_ff;
  logic err_ff;
  logic kind_ff;
  logic last_div;
  logic last_us;

  // a zero divisor behaves as one so the tick never stops
  assign last_div = (div_ff >= cif.clocks_per_microsecond - 8'h01) || (cif.clocks_per_microsecond == 8'h00);
  assign last_us = (us_ff == 16'(COMMIT_US - 1));

  // microsecond tick from the software-loaded count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 8'h00;
    end else if (last_div) begin
      div_ff <= 8'h00;
    end else begin
      div_ff <= div_ff + 8'h01;
    end
  end
  assign cif.usec_tick = last_div;

  // commit runs for a fixed number of microseconds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= cst_idle;
      us_ff <= 16'h0000;
      kind_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        cst_idle: begin
          if (cif.start) begin
            state_ff <= cst_prog;
            us_ff <= 16'h0000;
            kind_ff <= cif.kind;
          end
        end
        cst_prog: begin
          if (last_div) begin
            us_ff <= us_ff + 16'h0001;
            if (last_us) begin
              state_ff <= cst_done;
            end
          end
        end
        cst_done: begin
          state_ff <= cst_idle;
        end
      endcase
    end
  end

  // any store error during the burn fails the commit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_ff <= 1'b0;
    end else if (state_ff == cst_idle && cif.start) begin
      err_ff <= 1'b0;
    end else if (state_ff == cst_prog && nv_error) begin
      err_ff <= 1'b1;
    end
  end

  assign cif.busy = (state_ff != cst_idle);
  assign cif.done = (state_ff == cst_done);
  assign cif.err = err_ff;
  assign nv_wr_en = (state_ff == cst_prog);
  assign nv_wr_kind = kind_ff;
endmodule

// file: fbp_core.sv
// The address map and register access over APB were decided locally.
module fbp_core
  import fbp_pkg::*;
#(
  parameter int unsigned NUM_BLOCKS = 32,
  parameter int unsigned COMMIT_US = COMMIT_TIME_US
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire fbp_pkg::fbp_acc_t acc_type,
  output logic acc_allow,
  input wire logic prog_done,
  output logic usec_tick,
  input wire logic [2*NUM_BLOCKS-1:0] nv_prot_image,
  input wire logic [31:0] nv_user0,
  input wire logic [31:0] nv_user1,
  input wire logic nv_error,
  output logic nv_wr_en,
  output logic nv_wr_kind,
  output logic [2*NUM_BLOCKS-1:0] nv_wr_prot,
  output logic [31:0] nv_wr_user0,
  output logic [31:0] nv_wr_user1,
  output logic irq
);
  import fbp_pkg::*;

  localparam int unsigned IDX_W = (NUM_BLOCKS > 1) ? $clog2(NUM_BLOCKS) : 1;
  localparam logic [20:0] NUM_BLOCKS_W = 21'(NUM_BLOCKS);

  fbp_commit_if cif ();

  logic [1:0] prot_ff [NUM_BLOCKS];
  logic load_ff;
  logic [31:0] prot_addr_ff;
  logic [7:0] usec_ff;
  logic [31:0] user0_ff;
  logic [31:0] user1_ff;
  logic done_ff;
  logic err_ff;
  logic set_fail_ff;
  logic kind_ff;
  logic [INT_W-1:0] int_stat_ff;
  logic [INT_W-1:0] int_mask_ff;
  logic [31:0] prdata_ff;

  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic hit;
  logic [31:0] rd_mux;
  logic addr_ok;
  logic [IDX_W-1:0] set_idx;
  logic [1:0] cur_prot;
  logic [1:0] new_prot;
  logic val_ok;
  logic set_req;
  logic set_ok;
  logic set_apply;
  logic [IDX_W-1:0] acc_idx;
  logic acc_in_range;
  logic [1:0] acc_prot;
  logic violation;
  logic start_prot;
  logic start_user;

  // apb phases; answers in the access cycle, no wait states
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign pready = psel && penable;
  assign prdata = prdata_ff;

  // address decode; unmapped offsets answer with an error
  always_comb begin
    hit = (paddr[31:8] == 24'h00_0000) && (paddr[1:0] == 2'h0);
    unique case (paddr[7:0])
      OFS_CTRL, OFS_PROT_ADDR, OFS_PROT_VAL, OFS_STATUS, OFS_USEC,
      OFS_USER0, OFS_USER1, OFS_INT_STAT, OFS_INT_MASK: begin
      end
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !hit;

  // block selected for query and change
  assign addr_ok = (prot_addr_ff[BLOCK_SHIFT-1:0] == '0) && (prot_addr_ff[31:BLOCK_SHIFT] < NUM_BLOCKS_W);
  assign set_idx = prot_addr_ff[BLOCK_SHIFT +: IDX_W];
  assign cur_prot = addr_ok ? prot_ff[set_idx] : PROT_NONE;

  // protection change check: tighten only, never out of fetch-only
  assign new_prot = pwdata[1:0];
  assign val_ok = (pwdata[31:2] == 30'h0000_0000) && (new_prot != PROT_NONE);
  assign set_req = wr_acc && hit && (paddr[7:0] == OFS_PROT_VAL) && !load_ff;
  assign set_ok = addr_ok && val_ok && !cif.busy && (new_prot >= cur_prot);
  assign set_apply = set_req && set_ok && (new_prot > cur_prot) && (cur_prot != prot_fetch_only);

  // one protection field per block
  generate
    for (genvar i = 0; i < NUM_BLOCKS; i++) begin : g_blk
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          prot_ff[i] <= prot_unrestricted;
        end else if (load_ff) begin
          prot_ff[i] <= nv_prot_image[2*i +: 2];
        end else if (set_apply && (set_idx == IDX_W'(i))) begin
          prot_ff[i] <= new_prot;
        end
      end
      assign nv_wr_prot[2*i +: 2] = prot_ff[i];
    end
  endgenerate

  // committed image is picked up on the first edge after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_ff <= 1'b1;
    end else begin
      load_ff <= 1'b0;
    end
  end

  // block address register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_addr_ff <= RST_WORD;
    end else if (wr_acc && hit && paddr[7:0] == OFS_PROT_ADDR) begin
      prot_addr_ff <= pwdata;
    end
  end

  // outcome of the last protection change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_fail_ff <= 1'b0;
    end else if (set_req) begin
      set_fail_ff <= !set_ok;
    end
  end

  // clocks per microsecond; paces the commit timer and the exported usec_tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usec_ff <= USEC_RST;
    end else if (wr_acc && hit && paddr[7:0] == OFS_USEC) begin
      usec_ff <= pwdata[7:0];
    end
  end
  assign usec_tick = cif.usec_tick;

  // user words; held still while a user commit burns them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      user0_ff <= RST_WORD;
      user1_ff <= RST_WORD;
    end else if (load_ff) begin
      user0_ff <= nv_user0;
      user1_ff <= nv_user1;
    end else if (wr_acc && hit && !cif.busy) begin
      if (paddr[7:0] == OFS_USER0) begin
        user0_ff <= pwdata;
      end
      if (paddr[7:0] == OFS_USER1) begin
        user1_ff <= pwdata;
      end
    end
  end
  assign nv_wr_user0 = user0_ff;
  assign nv_wr_user1 = user1_ff;

  // commit requests; ignored while one is running
  assign start_prot = wr_acc && hit && (paddr[7:0] == OFS_CTRL) && !load_ff && !cif.busy
                      && pwdata[CTRL_COMMIT_PROT];
  assign start_user = wr_acc && hit && (paddr[7:0] == OFS_CTRL) && !load_ff && !cif.busy
                      && !pwdata[CTRL_COMMIT_PROT] && pwdata[CTRL_COMMIT_USER];
  assign cif.start = start_prot || start_user;
  assign cif.kind = start_user;
  assign cif.clocks_per_microsecond = usec_ff;

  fbp_commit_seq #(
    .COMMIT_US(COMMIT_US)
  ) u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .cif(cif.seq),
    .nv_error(nv_error),
    .nv_wr_en(nv_wr_en),
    .nv_wr_kind(nv_wr_kind)
  );

  // commit result flags for polling software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_ff <= 1'b0;
      err_ff <= 1'b0;
      kind_ff <= 1'b0;
    end else if (cif.start) begin
      done_ff <= 1'b0;
      err_ff <= 1'b0;
      kind_ff <= cif.kind;
    end else if (cif.done) begin
      done_ff <= 1'b1;
      err_ff <= cif.err;
    end
  end

  // access check against the block's protection
  assign acc_in_range = (acc_addr[31:BLOCK_SHIFT] < NUM_BLOCKS_W);
  assign acc_idx = acc_addr[BLOCK_SHIFT +: IDX_W];
  assign acc_prot = acc_in_range ? prot_ff[acc_idx] : prot_unrestricted;
  always_comb begin
    acc_allow = 1'b1;
    unique case (acc_prot)
      prot_no_write: acc_allow = (acc_type == acc_data_read) || (acc_type == acc_fetch);
      prot_fetch_only: acc_allow = (acc_type == acc_fetch);
      default: acc_allow = 1'b1;
    endcase
  end
  assign violation = acc_valid && !acc_allow;

  // sticky events; a read clears only what it returned, so a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_ff <= RST_INT;
    end else begin
      int_stat_ff[INT_ACCESS] <= violation || (int_stat_ff[INT_ACCESS] && !(rd_clr() && prdata_ff[INT_ACCESS]));
      int_stat_ff[INT_PROG] <= prog_done || (int_stat_ff[INT_PROG] && !(rd_clr() && prdata_ff[INT_PROG]));
      int_stat_ff[INT_COMMIT] <= cif.done || (int_stat_ff[INT_COMMIT] && !(rd_clr() && prdata_ff[INT_COMMIT]));
    end
  end

  function automatic logic rd_clr();
    return rd_acc && hit && (paddr[7:0] == OFS_INT_STAT);
  endfunction

  // interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask_ff <= RST_INT;
    end else if (wr_acc && hit && paddr[7:0] == OFS_INT_MASK) begin
      int_mask_ff <= pwdata[INT_W-1:0];
    end
  end
  assign irq = |(int_stat_ff & int_mask_ff);

  // read mux, latched in the setup cycle so read data leaves a flop
  always_comb begin
    rd_mux = RST_WORD;
    unique case (paddr[7:0])
      OFS_PROT_ADDR: rd_mux = prot_addr_ff;
      OFS_PROT_VAL: rd_mux = {30'h0000_0000, cur_prot};
      OFS_STATUS: rd_mux = {27'h000_0000, kind_ff, set_fail_ff, err_ff, done_ff, cif.busy};
      OFS_USEC: rd_mux = {24'h00_0000, usec_ff};
      OFS_USER0: rd_mux = user0_ff;
      OFS_USER1: rd_mux = user1_ff;
      OFS_INT_STAT: rd_mux = {29'h0000_0000, int_stat_ff};
      OFS_INT_MASK: rd_mux = {29'h0000_0000, int_mask_ff};
      default: rd_mux = RST_WORD;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= RST_WORD;
    end else if (setup) begin
      prdata_ff <= (hit && !pwrite) ? rd_mux : RST_WORD;
    end
  end
endmodule

// file: fbp_core_chk.sv
module fbp_core_chk
  import fbp_pkg::*;
#(
  parameter int unsigned NUM_BLOCKS = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic acc_valid,
  input wire fbp_pkg::fbp_acc_t acc_type,
  input wire logic acc_allow,
  input wire logic prog_done,
  input wire logic nv_wr_en,
  input wire logic [2*NUM_BLOCKS-1:0] nv_wr_prot,
  input wire logic [31:0] nv_wr_user0,
  input wire logic irq
);
  logic up_ff;
  // first edge after release is the permanent-copy load, not a request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_ff <= 1'b0;
    end else begin
      up_ff <= 1'b1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  zero_wait_a: assert property (psel && penable |-> pready) else $error("no ready in access");
  bad_addr_a: assert property ((psel && penable && paddr[31:8] != 24'h0 |-> pslverr) and
    (pslverr |-> psel && penable)) else $error("slave error misplaced");
  fetch_open_a: assert property (acc_valid && acc_type == acc_fetch |-> acc_allow)
    else $error("fetch refused");
  commit_go_a: assert property (up_ff && !nv_wr_en && !$past(nv_wr_en) && psel && penable && pwrite
    && paddr == 32'h0000_0000 && pwdata[CTRL_COMMIT_PROT] |-> ##[1:2] nv_wr_en) else $error("commit not started");
  burn_prot_a: assert property (nv_wr_en && $past(nv_wr_en) |-> $stable(nv_wr_prot))
    else $error("protection moved in burn");
  burn_user_a: assert property (nv_wr_en && $past(nv_wr_en) |-> $stable(nv_wr_user0))
    else $error("user moved in burn");
  irq_cause_a: assert property ($rose(irq) |-> $past(acc_valid && !acc_allow) || $past(prog_done)
    || $past(psel && penable && pwrite) || $past(nv_wr_en, 2) || $past(nv_wr_en, 3)) else $error("irq without cause");
  prot_move_a: assert property (up_ff && $past(up_ff) && $changed(nv_wr_prot)
    |-> $past(psel && penable && pwrite)) else $error("protection moved alone");
endmodule

bind fbp_core fbp_core_chk #(.NUM_BLOCKS(NUM_BLOCKS)) fbp_core_chk_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .acc_valid, .acc_type, .acc_allow, .prog_done, .nv_wr_en,
  .nv_wr_prot, .nv_wr_user0, .irq);

// file: fbp_core_bench.sv
module fbp_core_bench;
  import fbp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, acc_valid, acc_allow, prog_done;
  logic usec_tick, nv_error, nv_wr_en, nv_wr_kind, irq, rd_err;
  logic [31:0] paddr, pwdata, prdata, acc_addr, nv_user0, nv_user1, nv_wr_user0, nv_wr_user1, rd;
  logic [63:0] nv_prot_image, nv_wr_prot;
  fbp_acc_t acc_type;
  int mismatches, n_tests, cyc, len;
  logic [3:0] amask [3] = '{4'hF, 4'h3, 4'h2};
  int ablk [3] = '{0, 2, 1};

  fbp_core #(.NUM_BLOCKS(32), .COMMIT_US(2)) fbp_core_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_type(acc_type), .acc_allow(acc_allow),
    .prog_done(prog_done), .usec_tick(usec_tick), .nv_prot_image(nv_prot_image), .nv_user0(nv_user0),
    .nv_user1(nv_user1), .nv_error(nv_error), .nv_wr_en(nv_wr_en), .nv_wr_kind(nv_wr_kind),
    .nv_wr_prot(nv_wr_prot), .nv_wr_user0(nv_wr_user0), .nv_wr_user1(nv_wr_user1), .irq(irq));

  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end
  // permanent store: a burn lands unless the store reports an error
  always @(posedge pclk) begin
    if (nv_wr_en && !nv_error && nv_wr_kind) begin
      nv_user0 <= nv_wr_user0;
      nv_user1 <= nv_wr_user1;
    end else if (nv_wr_en && !nv_error) begin
      nv_prot_image <= nv_wr_prot;
    end
  end
  // watchdog, far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      wrap_up;
    end
  end

  task wrap_up;
    if (mismatches == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // idle cycle at the end so back-to-back calls never drive psel twice at one edge
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    rd_err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(0, 32'(a), 0);
    chk(rd, exp);
  endtask
  task stat(input int b, input logic exp);
    apb(0, 32'(OFS_STATUS), 0);
    chk(32'(rd[b]), 32'(exp));
  endtask
  task pset(input int b, input logic [31:0] v);
    apb(1, 32'(OFS_PROT_ADDR), 32'(b * 2048));
    apb(1, 32'(OFS_PROT_VAL), v);
  endtask
  task acc(input int b, input fbp_acc_t t, input logic exp);
    acc_valid <= 1;
    acc_addr <= 32'(b * 2048 + 4);
    acc_type <= t;
    @(negedge pclk);
    chk(32'(acc_allow), 32'(exp));
    @(posedge pclk);
    acc_valid <= 0;
    @(posedge pclk);
  endtask
  task commit(input logic [31:0] c);
    apb(1, 32'(OFS_CTRL), c);
    len = 0;
    while (!nv_wr_en) @(posedge pclk);
    while (nv_wr_en) begin
      len++;
      @(posedge pclk);
    end
    repeat (3) @(posedge pclk);
  endtask
  task pulse_done(input logic exp_irq);
    prog_done <= 1;
    @(posedge pclk);
    prog_done <= 0;
    @(posedge pclk);
    chk(32'(irq), 32'(exp_irq));
  endtask

  task t_reset;
    rdc(OFS_USEC, 32'h0000_0014);
    rdc(OFS_USER0, 32'h1234_5678);
    apb(1, 32'(OFS_PROT_ADDR), 32'h0000_2800);
    rdc(OFS_PROT_VAL, 32'h0000_0002);
    // error answer is only visible in the access cycle, so apb keeps it
    apb(0, 32'h0000_0100, 0);
    chk(32'(rd_err), 1);
    chk(32'(pslverr), 0);
  endtask
  task t_prot;
    pset(1, 1);
    rdc(OFS_PROT_VAL, 1);
    pset(1, 0);
    stat(ST_SET_FAIL, 1);
    rdc(OFS_PROT_VAL, 1);
    pset(1, 2);
    rdc(OFS_PROT_VAL, 2);
    pset(1, 1);
    rdc(OFS_PROT_VAL, 2);
    pset(2, 3);
    stat(ST_SET_FAIL, 1);
    rdc(OFS_PROT_VAL, 0);
    apb(1, 32'(OFS_PROT_ADDR), 32'h0000_0804);
    rdc(OFS_PROT_VAL, 3);
    pset(2, 1);
    stat(ST_SET_FAIL, 0);
    // rows: unrestricted, no-write, fetch-only; bit index is the access kind
    for (int i = 0; i < 3; i++) begin
      for (int t = 0; t < 4; t++) begin
        acc(ablk[i], fbp_acc_t'(t), amask[i][t]);
      end
    end
    acc(32, acc_erase, 1);
  endtask
  task t_irq;
    chk(32'(irq), 0);
    apb(1, 32'(OFS_INT_MASK), 32'h0000_0003);
    chk(32'(irq), 1);
    rdc(OFS_INT_STAT, 32'h0000_0001);
    chk(32'(irq), 0);
    pulse_done(1);
    rdc(OFS_INT_STAT, 32'h0000_0002);
    apb(1, 32'(OFS_INT_MASK), 0);
    pulse_done(0);
    rdc(OFS_INT_STAT, 32'h0000_0002);
  endtask
  task t_commit;
    apb(1, 32'(OFS_USEC), 3);
    rdc(OFS_USEC, 3);
    // tick period follows the loaded count; sampled mid-cycle where it is settled
    do @(negedge pclk); while (usec_tick !== 1'b1);
    len = 0;
    do begin
      @(negedge pclk);
      len++;
    end while (usec_tick !== 1'b1);
    chk(len, 3);
    apb(1, 32'(OFS_USER0), 32'hA5A5_0001);
    apb(1, 32'(OFS_USER1), 32'h5A5A_0002);
    rdc(OFS_USER1, 32'h5A5A_0002);
    commit(2);
    chk(nv_user0, 32'hA5A5_0001);
    stat(ST_DONE, 1);
    chk(32'(len >= 3 && len <= 5), 1);
    nv_error <= 1;
    commit(1);
    nv_error <= 0;
    stat(ST_ERR, 1);
    commit(1);
    stat(ST_ERR, 0);
    pset(3, 1);
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(1, 32'(OFS_PROT_ADDR), 32'h0000_1800);
    rdc(OFS_PROT_VAL, 0);
    apb(1, 32'(OFS_PROT_ADDR), 32'h0000_0800);
    rdc(OFS_PROT_VAL, 2);
    rdc(OFS_USER1, 32'h5A5A_0002);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, acc_valid, prog_done, nv_error} = '0;
    {paddr, pwdata, acc_addr, nv_user1} = '0;
    nv_user0 = 32'h1234_5678;
    nv_prot_image = 64'h0000_0000_0000_0800;
    acc_type = acc_data_read;
    cyc = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset;
    t_prot;
    t_irq;
    t_commit;
    wrap_up;
  end
endmodule
